/* File: dv/tb_selective_subsystem_reset.sv */
// self-checking testbench for the selective subsystem reset control
// assumes ssr_pkg and the rtl modules are compiled first; the bench drives every port itself
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, exp, got) begin \
   checks_done++; \
   if ((got) !== (exp)) begin \
      miscompares++; \
      $display("unexpected %s expected %h seen %h", nm, exp, got); \
   end \
end
module tb_selective_subsystem_reset
   import ssr_pkg::*;
;
   // ---------------------------------------------------------------
   // signals and constants
   // ---------------------------------------------------------------
   localparam logic [SSR_PTR_W-1:0] TXV = 32'h1111_2222; // preload for tx pointer
   localparam logic [SSR_PTR_W-1:0] RXV = 32'h3333_4444; // preload for rx pointer
   localparam logic [SSR_THR_W-1:0] THV = 16'h0055;      // preload for threshold
   int                     miscompares;
   int                     checks_done;
   logic                   clk;
   logic                   sys_rst;
   logic                   ctrl_write;
   logic                   w_trig, r_trig, t_trig;
   logic                   xf, fi, nt, ho, se;
   logic                   tx_ptr_load, rx_ptr_load, thr_load;
   logic                   tx_done_set, rx_done_set, act_start, act_end;
   logic [SSR_PTR_W-1:0]   tx_ptr_value, rx_ptr_value;
   logic [SSR_THR_W-1:0]   thr_value;
   logic                   reset_busy;
   logic [SSR_CTRL_W-1:0]  status;
   logic                   txx, rxx, txf, rxf, txn, rxn, txh, rxh, txs, rxs;
   logic [SSR_PTR_W-1:0]   tx_ptr, rx_ptr;
   logic [SSR_THR_W-1:0]   thr;
   logic                   tx_done, rx_done, tx_act;
   wire logic [9:0]        clr;
   // clear pulses gathered, tx before rx for each group
   assign clr = {txx, rxx, txf, rxf, txn, rxn, txh, rxh, txs, rxs};

   ssr_top u_dut (
      .clk(clk), .sys_rst(sys_rst), .ctrl_write(ctrl_write),
      .whole_device_reset_trigger(w_trig), .receive_reset_trigger(r_trig),
      .transmit_reset_trigger(t_trig), .transfer_select(xf), .fifo_select(fi),
      .network_select(nt), .host_select(ho), .self_setup_select(se),
      .tx_ptr_load(tx_ptr_load), .tx_ptr_value(tx_ptr_value),
      .rx_ptr_load(rx_ptr_load), .rx_ptr_value(rx_ptr_value),
      .thr_load(thr_load), .thr_value(thr_value),
      .tx_done_set(tx_done_set), .rx_done_set(rx_done_set),
      .tx_active_start(act_start), .tx_active_end(act_end),
      .reset_busy(reset_busy), .reset_ctrl_status(status),
      .tx_xfer_clear(txx), .rx_xfer_clear(rxx), .tx_fifo_clear(txf), .rx_fifo_clear(rxf),
      .tx_net_clear(txn), .rx_net_clear(rxn), .tx_host_clear(txh), .rx_host_clear(rxh),
      .tx_self_clear(txs), .rx_self_clear(rxs),
      .tx_descriptor_list_pointer(tx_ptr), .rx_descriptor_list_pointer(rx_ptr),
      .tx_launch_threshold(thr), .tx_transfer_done_flag(tx_done),
      .rx_transfer_done_flag(rx_done), .tx_transfer_active_flag(tx_act)
   );

   // ---------------------------------------------------------------
   // shared tasks
   // ---------------------------------------------------------------
   // move to 2 ns after the next rising edge, where inputs change
   task automatic step();
      @(posedge clk);
      #2;
   endtask

   // b = {self, host, net, fifo, xfer, tx, rx, whole}; one-cycle write strobe
   task automatic write_ctrl(input logic [7:0] b);
      ctrl_write = 1'b1;
      {se, ho, nt, fi, xf, t_trig, r_trig, w_trig} = b;
      step();
      ctrl_write = 1'b0;
      {se, ho, nt, fi, xf, t_trig, r_trig, w_trig} = 8'h00;
   endtask

   // loads every held register in one cycle
   task automatic preload();
      {tx_ptr_load, rx_ptr_load, thr_load, tx_done_set, rx_done_set, act_start} = 6'h3f;
      tx_ptr_value = TXV;
      rx_ptr_value = RXV;
      thr_value    = THV;
      step();
      {tx_ptr_load, rx_ptr_load, thr_load, tx_done_set, rx_done_set, act_start} = 6'h00;
   endtask

   // one control write, then pulses, status and cleared registers judged
   task automatic reset_case(input logic [7:0] b);
      logic       trig;
      logic       tx_hit;
      logic       rx_hit;
      logic [9:0] exp_clr;
      trig   = |b[2:0];
      tx_hit = b[3] & (b[0] | b[2]);
      rx_hit = b[3] & (b[0] | b[1]);
      for (int i = 0; i < 5; i++) begin
         exp_clr[9-2*i] = b[3+i] & (b[0] | b[2]);
         exp_clr[8-2*i] = b[3+i] & (b[0] | b[1]);
      end
      preload();
      write_ctrl(b);
      `CHK("reset_busy", trig, reset_busy)
      `CHK("clear pulses", exp_clr, clr)
      `CHK("status", {8'h00, b, 16'h0000}, status)
      step();
      `CHK("reset_busy after", 1'b0, reset_busy)
      `CHK("clear pulses after", 10'h000, clr)
      `CHK("status after", {8'h00, (trig ? {b[7:4], 4'h0} : b), 16'h0000}, status)
      `CHK("tx pointer", (tx_hit ? SSR_PTR_RST : TXV), tx_ptr)
      `CHK("tx done", (tx_hit ? SSR_FLAG_RST : 1'b1), tx_done)
      `CHK("tx active", (tx_hit ? SSR_FLAG_RST : 1'b1), tx_act)
      `CHK("rx pointer", (rx_hit ? SSR_PTR_RST : RXV), rx_ptr)
      `CHK("rx done", (rx_hit ? SSR_FLAG_RST : 1'b1), rx_done)
      `CHK("threshold", ((b[4] & (b[0] | b[2])) ? SSR_THR_RST : THV), thr)
   endtask

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   // outputs straight after reset
   task automatic test_reset_values();
      `CHK("status at reset", 32'h0000_0000, status)
      `CHK("busy at reset", 1'b0, reset_busy)
      `CHK("pulses at reset", 10'h000, clr)
      `CHK("tx pointer at reset", SSR_PTR_RST, tx_ptr)
      `CHK("rx pointer at reset", SSR_PTR_RST, rx_ptr)
      `CHK("threshold at reset", SSR_THR_RST, thr)
      `CHK("flags at reset", 3'h0, {tx_done, rx_done, tx_act})
   endtask

   // engine loads and the active flag start and end pulses
   task automatic test_engine_loads();
      preload();
      `CHK("loaded", {TXV, RXV, THV}, {tx_ptr, rx_ptr, thr})
      `CHK("flags set", 3'h7, {tx_done, rx_done, tx_act})
      act_end = 1'b1;
      step();
      `CHK("active ended", 1'b0, tx_act)
      act_start = 1'b1;
      step();
      {act_start, act_end} = 2'h0;
      `CHK("start wins", 1'b1, tx_act)
   endtask

   // write during the busy cycle is ignored, the one after is taken
   task automatic test_refused_write();
      preload();
      // strobe held high over two edges: the second lands in the busy cycle
      ctrl_write = 1'b1;
      {se, ho, nt, fi, xf, t_trig, r_trig, w_trig} = 8'h0c;
      step();
      {se, ho, nt, fi, xf, t_trig, r_trig, w_trig} = 8'h0a;
      step();
      ctrl_write = 1'b0;
      {se, ho, nt, fi, xf, t_trig, r_trig, w_trig} = 8'h00;
      `CHK("refused rx pulse", 1'b0, rxx)
      `CHK("refused status", 32'h0000_0000, status)
      `CHK("refused rx pointer", RXV, rx_ptr)
      write_ctrl(8'b0000_1010);
      `CHK("accepted rx pulse", 1'b1, rxx)
      step();
      `CHK("rx pointer cleared", SSR_PTR_RST, rx_ptr)
   endtask

   // reset raised in the busy cycle drops the pulses, the status, both pointers and the threshold
   task automatic test_mid_reset();
      preload();
      write_ctrl(8'h0a);
      `CHK("busy before mid reset", 1'b1, reset_busy)
      sys_rst = 1'b1;
      step();
      `CHK("pulses in mid reset", 10'h000, clr)
      `CHK("status in mid reset", 32'h0000_0000, status)
      `CHK("pointers in mid reset", {SSR_PTR_RST, SSR_PTR_RST}, {tx_ptr, rx_ptr})
      `CHK("threshold in mid reset", SSR_THR_RST, thr)
      sys_rst = 1'b0;
      step();
      write_ctrl(8'h0c);
      `CHK("tx pulse after mid reset", 1'b1, txx)
   endtask

   // ---------------------------------------------------------------
   // closing and watchdog
   // ---------------------------------------------------------------
   task automatic conclude();
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // clock at 40 MHz
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // cuts a hang short well beyond the expected run
   initial begin
      #(25 * 4000);
      miscompares++;
      conclude();
   end

   // main sequence
   initial begin
      miscompares = 0;
      checks_done = 0;
      sys_rst = 1'b1;
      ctrl_write = 1'b0;
      {se, ho, nt, fi, xf, t_trig, r_trig, w_trig} = 8'h00;
      {tx_ptr_load, rx_ptr_load, thr_load, tx_done_set, rx_done_set} = 5'h00;
      {act_start, act_end} = 2'h0;
      tx_ptr_value = '0;
      rx_ptr_value = '0;
      thr_value = '0;
      repeat (5) @(posedge clk);
      #2;
      sys_rst = 1'b0;
      test_reset_values();
      test_engine_loads();
      reset_case(8'b0000_1100); // transmit reset with transfer group
      reset_case(8'b0000_1010); // receive reset with transfer group
      reset_case(8'b1111_1001); // whole-device reset, every group
      reset_case(8'b0001_0100); // transmit reset, fifo group only
      reset_case(8'b1111_1010); // receive reset, every group
      reset_case(8'b0111_0000); // selects without a trigger
      reset_case(8'b0000_1110); // receive and transmit together
      test_refused_write();
      test_mid_reset();
      conclude();
   end
endmodule
`default_nettype wire

/* File: include/ssr_pkg.sv */
// package for the selective subsystem reset control
// assumes a single 40 MHz device clock and a synchronous active-high reset
package ssr_pkg;
   // ---------------------------------------------------------------
   // control word bit positions
   // ---------------------------------------------------------------
   localparam int unsigned SSR_BIT_WHOLE = 16;
   localparam int unsigned SSR_BIT_RX    = 17;
   localparam int unsigned SSR_BIT_TX    = 18;
   localparam int unsigned SSR_BIT_XFER  = 19;
   localparam int unsigned SSR_BIT_FIFO  = 20;
   localparam int unsigned SSR_BIT_NET   = 21;
   localparam int unsigned SSR_BIT_HOST  = 22;
   localparam int unsigned SSR_BIT_SELF  = 23;
   localparam int unsigned SSR_CTRL_W    = 32;

   // ---------------------------------------------------------------
   // register widths and reset values
   // ---------------------------------------------------------------
   localparam int unsigned SSR_PTR_W = 32;
   localparam int unsigned SSR_THR_W = 16;
   localparam logic [SSR_PTR_W-1:0] SSR_PTR_RST  = 32'h0000_0000;
   localparam logic [SSR_THR_W-1:0] SSR_THR_RST  = 16'h0000;
   localparam logic                 SSR_FLAG_RST = 1'h0;

   // sequencer phases
   typedef enum logic [0:0] {SSR_IDLE, SSR_APPLY} ssr_phase_e;

   // a select group is hit when selected and its side or the whole device is triggered
   function automatic logic ssr_hit(input logic whole, input logic side, input logic sel);
      return sel & (whole | side);
   endfunction
endpackage

/* File: rtl/ssr_hold_reg.sv */
// holding register that a reset group clears and the engine loads
// assumes load and clear are single-cycle pulses on clk
`timescale 1ns/10ps
`default_nettype none
module ssr_hold_reg
   import ssr_pkg::*;
#(
   parameter int unsigned          W   = 1,
   parameter logic [W-1:0]         RST = '0
) (
   input  wire logic         clk,
   input  wire logic         sys_rst,
   input  wire logic         load,
   input  wire logic [W-1:0] load_value,
   input  wire logic         clear,
   output logic      [W-1:0] value
);
   typedef struct packed {
      logic [W-1:0] value;
   } ssr_hold_s;

   ssr_hold_s st;
   ssr_hold_s next_st;

   // an engine load in the clearing cycle wins over the clear
   always_comb begin
      next_st = st;
      if (load) begin
         next_st.value = load_value;
      end else if (clear) begin
         next_st.value = RST;
      end
   end

   // state register
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         st.value <= RST;
      end else begin
         st <= next_st;
      end
   end

   assign value = st.value;
endmodule
`default_nettype wire

/* File: rtl/ssr_top.sv */
// selective subsystem reset sequencer with its cleared registers
// assumes control bits arrive as plain ports with a one-cycle write strobe
`timescale 1ns/10ps
`default_nettype none
module ssr_top
   import ssr_pkg::*;
(
   input  wire logic                 clk,
   input  wire logic                 sys_rst,
   input  wire logic                 ctrl_write,
   input  wire logic                 whole_device_reset_trigger,
   input  wire logic                 receive_reset_trigger,
   input  wire logic                 transmit_reset_trigger,
   input  wire logic                 transfer_select,
   input  wire logic                 fifo_select,
   input  wire logic                 network_select,
   input  wire logic                 host_select,
   input  wire logic                 self_setup_select,
   input  wire logic                 tx_ptr_load,
   input  wire logic [SSR_PTR_W-1:0] tx_ptr_value,
   input  wire logic                 rx_ptr_load,
   input  wire logic [SSR_PTR_W-1:0] rx_ptr_value,
   input  wire logic                 thr_load,
   input  wire logic [SSR_THR_W-1:0] thr_value,
   input  wire logic                 tx_done_set,
   input  wire logic                 rx_done_set,
   input  wire logic                 tx_active_start,
   input  wire logic                 tx_active_end,
   output logic                      reset_busy,
   output logic [SSR_CTRL_W-1:0]     reset_ctrl_status,
   output logic                      tx_xfer_clear,
   output logic                      rx_xfer_clear,
   output logic                      tx_fifo_clear,
   output logic                      rx_fifo_clear,
   output logic                      tx_net_clear,
   output logic                      rx_net_clear,
   output logic                      tx_host_clear,
   output logic                      rx_host_clear,
   output logic                      tx_self_clear,
   output logic                      rx_self_clear,
   output logic [SSR_PTR_W-1:0]      tx_descriptor_list_pointer,
   output logic [SSR_PTR_W-1:0]      rx_descriptor_list_pointer,
   output logic [SSR_THR_W-1:0]      tx_launch_threshold,
   output logic                      tx_transfer_done_flag,
   output logic                      rx_transfer_done_flag,
   output logic                      tx_transfer_active_flag
);
   // ---------------------------------------------------------------
   // sequencer state
   // ---------------------------------------------------------------
   typedef struct packed {
      ssr_phase_e phase;
      logic       trig_whole;
      logic       trig_rx;
      logic       trig_tx;
      logic       sel_xfer;
      logic       sel_fifo;
      logic       sel_net;
      logic       sel_host;
      logic       sel_self;
      logic       clr_tx_xfer;
      logic       clr_rx_xfer;
      logic       clr_tx_fifo;
      logic       clr_rx_fifo;
      logic       clr_tx_net;
      logic       clr_rx_net;
      logic       clr_tx_host;
      logic       clr_rx_host;
      logic       clr_tx_self;
      logic       clr_rx_self;
   } ssr_state_s;

   ssr_state_s st;
   ssr_state_s next_st;
   logic       take_write;
   logic       any_trig;

   assign take_write = ctrl_write & (st.phase == SSR_IDLE);
   assign any_trig   = whole_device_reset_trigger | receive_reset_trigger
                     | transmit_reset_trigger;

   // write capture, one-cycle clear pulses, then self-clearing
   always_comb begin
      next_st = st;
      next_st.clr_tx_xfer = 1'b0;
      next_st.clr_rx_xfer = 1'b0;
      next_st.clr_tx_fifo = 1'b0;
      next_st.clr_rx_fifo = 1'b0;
      next_st.clr_tx_net  = 1'b0;
      next_st.clr_rx_net  = 1'b0;
      next_st.clr_tx_host = 1'b0;
      next_st.clr_rx_host = 1'b0;
      next_st.clr_tx_self = 1'b0;
      next_st.clr_rx_self = 1'b0;
      unique case (st.phase)
         SSR_IDLE: begin
            if (take_write) begin
               // selects are sampled with the same write
               next_st.sel_xfer = transfer_select;
               next_st.sel_fifo = fifo_select;
               next_st.sel_net  = network_select;
               next_st.sel_host = host_select;
               next_st.sel_self = self_setup_select;
               if (any_trig) begin
                  next_st.phase      = SSR_APPLY;
                  next_st.trig_whole = whole_device_reset_trigger;
                  next_st.trig_rx    = receive_reset_trigger;
                  next_st.trig_tx    = transmit_reset_trigger;
                  next_st.clr_tx_xfer = ssr_hit(whole_device_reset_trigger,
                     transmit_reset_trigger, transfer_select);
                  next_st.clr_rx_xfer = ssr_hit(whole_device_reset_trigger,
                     receive_reset_trigger, transfer_select);
                  next_st.clr_tx_fifo = ssr_hit(whole_device_reset_trigger,
                     transmit_reset_trigger, fifo_select);
                  next_st.clr_rx_fifo = ssr_hit(whole_device_reset_trigger,
                     receive_reset_trigger, fifo_select);
                  next_st.clr_tx_net = ssr_hit(whole_device_reset_trigger,
                     transmit_reset_trigger, network_select);
                  next_st.clr_rx_net = ssr_hit(whole_device_reset_trigger,
                     receive_reset_trigger, network_select);
                  next_st.clr_tx_host = ssr_hit(whole_device_reset_trigger,
                     transmit_reset_trigger, host_select);
                  next_st.clr_rx_host = ssr_hit(whole_device_reset_trigger,
                     receive_reset_trigger, host_select);
                  next_st.clr_tx_self = ssr_hit(whole_device_reset_trigger,
                     transmit_reset_trigger, self_setup_select);
                  next_st.clr_rx_self = ssr_hit(whole_device_reset_trigger,
                     receive_reset_trigger, self_setup_select);
               end
            end
         end
         SSR_APPLY: begin
            // triggers and the transfer select drop once the pulses are out
            next_st.phase      = SSR_IDLE;
            next_st.trig_whole = 1'b0;
            next_st.trig_rx    = 1'b0;
            next_st.trig_tx    = 1'b0;
            next_st.sel_xfer   = 1'b0;
         end
      endcase
   end

   // state register
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         st <= '{phase: SSR_IDLE, default: 1'b0};
      end else begin
         st <= next_st;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   // clear pulses and status word come straight from flops
   always_comb begin
      reset_ctrl_status = '0;
      reset_ctrl_status[SSR_BIT_WHOLE] = st.trig_whole;
      reset_ctrl_status[SSR_BIT_RX]    = st.trig_rx;
      reset_ctrl_status[SSR_BIT_TX]    = st.trig_tx;
      reset_ctrl_status[SSR_BIT_XFER]  = st.sel_xfer;
      reset_ctrl_status[SSR_BIT_FIFO]  = st.sel_fifo;
      reset_ctrl_status[SSR_BIT_NET]   = st.sel_net;
      reset_ctrl_status[SSR_BIT_HOST]  = st.sel_host;
      reset_ctrl_status[SSR_BIT_SELF]  = st.sel_self;
   end

   assign reset_busy    = (st.phase == SSR_APPLY);
   assign tx_xfer_clear = st.clr_tx_xfer;
   assign rx_xfer_clear = st.clr_rx_xfer;
   assign tx_fifo_clear = st.clr_tx_fifo;
   assign rx_fifo_clear = st.clr_rx_fifo;
   assign tx_net_clear  = st.clr_tx_net;
   assign rx_net_clear  = st.clr_rx_net;
   assign tx_host_clear = st.clr_tx_host;
   assign rx_host_clear = st.clr_rx_host;
   assign tx_self_clear = st.clr_tx_self;
   assign rx_self_clear = st.clr_rx_self;

   // ---------------------------------------------------------------
   // registers cleared by the groups
   // ---------------------------------------------------------------
   // transmit pointer follows the tx transfer group only
   ssr_hold_reg #(.W(SSR_PTR_W), .RST(SSR_PTR_RST)) u_tx_ptr (
      .clk        (clk),
      .sys_rst    (sys_rst),
      .load       (tx_ptr_load),
      .load_value (tx_ptr_value),
      .clear      (st.clr_tx_xfer),
      .value      (tx_descriptor_list_pointer)
   );

   // receive pointer follows the rx transfer group only
   ssr_hold_reg #(.W(SSR_PTR_W), .RST(SSR_PTR_RST)) u_rx_ptr (
      .clk        (clk),
      .sys_rst    (sys_rst),
      .load       (rx_ptr_load),
      .load_value (rx_ptr_value),
      .clear      (st.clr_rx_xfer),
      .value      (rx_descriptor_list_pointer)
   );

   // launch threshold belongs to the tx fifo group
   ssr_hold_reg #(.W(SSR_THR_W), .RST(SSR_THR_RST)) u_thr (
      .clk        (clk),
      .sys_rst    (sys_rst),
      .load       (thr_load),
      .load_value (thr_value),
      .clear      (st.clr_tx_fifo),
      .value      (tx_launch_threshold)
   );

   // done flags: set by the engine, set wins over the group clear
   ssr_hold_reg #(.W(1), .RST(SSR_FLAG_RST)) u_tx_done (
      .clk        (clk),
      .sys_rst    (sys_rst),
      .load       (tx_done_set),
      .load_value (1'b1),
      .clear      (st.clr_tx_xfer),
      .value      (tx_transfer_done_flag)
   );

   ssr_hold_reg #(.W(1), .RST(SSR_FLAG_RST)) u_rx_done (
      .clk        (clk),
      .sys_rst    (sys_rst),
      .load       (rx_done_set),
      .load_value (1'b1),
      .clear      (st.clr_rx_xfer),
      .value      (rx_transfer_done_flag)
   );

   // active flag: start sets, end drops, tx group clear drops
   ssr_hold_reg #(.W(1), .RST(SSR_FLAG_RST)) u_tx_active (
      .clk        (clk),
      .sys_rst    (sys_rst),
      .load       (tx_active_start | tx_active_end),
      .load_value (tx_active_start),
      .clear      (st.clr_tx_xfer),
      .value      (tx_transfer_active_flag)
   );

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking ssr_cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   rx_group_hit_a: assert property (
      take_write && receive_reset_trigger && transfer_select
      |=> rx_xfer_clear ##1 !rx_xfer_clear)
      else $error("rx trigger did not pulse the rx transfer clear");

   rx_self_clear_a: assert property (
      take_write && receive_reset_trigger |=> st.trig_rx ##1 !st.trig_rx)
      else $error("rx trigger did not clear itself");

   // a transmit-only trigger clears the tx fifo and leaves the rx fifo alone
   tx_group_hit_a: assert property (
      take_write && transmit_reset_trigger && fifo_select
      && !receive_reset_trigger && !whole_device_reset_trigger
      |=> tx_fifo_clear && !rx_fifo_clear)
      else $error("tx trigger fifo clear wrong");

   tx_self_clear_a: assert property (
      reset_busy |=> !st.trig_tx && !reset_busy)
      else $error("tx trigger did not clear itself");

   xfer_excluded_a: assert property (
      take_write && !transfer_select |=> !tx_xfer_clear && !rx_xfer_clear)
      else $error("transfer group cleared while not selected");

   xfer_select_drop_a: assert property (
      take_write && any_trig && transfer_select |=> st.sel_xfer ##1 !st.sel_xfer)
      else $error("transfer select did not return to zero");

   tx_ptr_cleared_a: assert property (
      tx_xfer_clear && !tx_ptr_load |=> tx_descriptor_list_pointer == SSR_PTR_RST)
      else $error("tx pointer not cleared");

   tx_active_kept_a: assert property (
      reset_busy && !st.trig_tx && !st.trig_whole && !tx_active_start && !tx_active_end
      |=> $stable(tx_transfer_active_flag))
      else $error("tx active flag disturbed by rx reset");

   rx_not_by_tx_a: assert property (
      reset_busy && !st.trig_rx && !st.trig_whole |-> !rx_xfer_clear)
      else $error("rx transfer group cleared by tx reset");

   thr_cleared_a: assert property (
      tx_fifo_clear && !thr_load |=> tx_launch_threshold == SSR_THR_RST)
      else $error("launch threshold not cleared");

   whole_both_a: assert property (
      take_write && whole_device_reset_trigger && fifo_select
      |=> tx_fifo_clear && rx_fifo_clear && st.trig_whole ##1 !st.trig_whole)
      else $error("whole reset missed a side");

   net_gate_a: assert property (
      reset_busy && !st.sel_net |-> !tx_net_clear && !rx_net_clear)
      else $error("network cleared while not selected");

   zero_write_a: assert property (
      take_write && !any_trig |=> !reset_busy && !tx_fifo_clear && !rx_fifo_clear)
      else $error("write without trigger started a reset");

   tx_reset_c: cover property (take_write && transmit_reset_trigger && transfer_select);
   rx_reset_c: cover property (take_write && receive_reset_trigger && fifo_select);
   whole_reset_c: cover property (take_write && whole_device_reset_trigger && network_select);
   refused_write_c: cover property (ctrl_write && reset_busy);
endmodule
`default_nettype wire
